/* include/sat_sub_params.svh */
// constants for the saturating subtract datapath: encodings, field positions, reset values
`ifndef SAT_SUB_PARAMS_SVH
`define SAT_SUB_PARAMS_SVH
// fixed opcode bits of the first halfword
`define SSD_HI_TOP        8'hFA
`define SSD_HI_TOP_MSB    15
`define SSD_HI_TOP_LSB    8
`define SSD_HI_SEL_MSB    7
`define SSD_HI_SEL_LSB    4
`define SSD_HI_WORD       4'h8
`define SSD_HI_SAX        4'hE
`define SSD_HI_HALF       4'hD
`define SSD_HI_BYTE       4'hC
// fixed opcode bits of the second halfword
`define SSD_LO_TOP        4'hF
`define SSD_LO_TOP_MSB    15
`define SSD_LO_TOP_LSB    12
`define SSD_LO_SEL_MSB    7
`define SSD_LO_SEL_LSB    4
`define SSD_LO_DADD       4'h9
`define SSD_LO_DSUB       4'hB
`define SSD_LO_SUB        4'hA
`define SSD_LO_PAR        4'h1
// register number fields
`define SSD_N_MSB         3
`define SSD_N_LSB         0
`define SSD_D_MSB         11
`define SSD_D_LSB         8
`define SSD_M_MSB         3
`define SSD_M_LSB         0
// reset values
`define SSD_RST_DATA      32'h0000_0000
`define SSD_RST_IDX       4'h0
`define SSD_RST_FLAG      1'b0
`endif

/* include/sat_sub_pkg.sv */
// types shared by the saturating subtract datapath
package sat_sub_pkg;
    // decoded operation, one-hot
    typedef enum logic [6:0] {
        OP_NONE = 7'h01,
        OP_DADD = 7'h02,
        OP_DSUB = 7'h04,
        OP_SUBW = 7'h08,
        OP_SAX  = 7'h10,
        OP_HALF = 7'h20,
        OP_BYTE = 7'h40
    } op_t;
endpackage

/* design/sat_lane.sv */
// one signed saturating add or subtract lane of parameterised width
`timescale 1ns/1ps
`default_nettype none
module sat_lane #(
    parameter int WIDTH = 16
) (
    input  wire logic [WIDTH-1:0] opA,
    input  wire logic [WIDTH-1:0] opB,
    input  wire logic             subtract,
    output logic      [WIDTH-1:0] result,
    output logic                  saturated
);
    // one guard bit is enough: a sum or difference of two W-bit values fits W+1 bits
    logic [WIDTH:0] extA;     // sign-extended operand a
    logic [WIDTH:0] extB;     // sign-extended operand b
    logic [WIDTH:0] rawSum;   // exact result
    logic           overflow; // guard bit disagrees with sign bit
    logic [WIDTH-1:0] limit;  // clamp value chosen by the true sign

    assign extA      = {opA[WIDTH-1], opA};
    assign extB      = {opB[WIDTH-1], opB};
    assign rawSum    = subtract ? (extA - extB) : (extA + extB);
    assign overflow  = rawSum[WIDTH] ^ rawSum[WIDTH-1];
    // negative overflow clamps to the most negative value, positive to the most positive
    assign limit     = rawSum[WIDTH] ? {1'b1, {(WIDTH-1){1'b0}}} : {1'b0, {(WIDTH-1){1'b1}}};
    assign result    = overflow ? limit : rawSum[WIDTH-1:0];
    assign saturated = overflow;
endmodule
`default_nettype wire

/* design/sat_sub_dsp_ops.sv */
// saturating subtract family and double-and-add/subtract execute datapath
// What this block does
// RULE1: double n saturating, add m saturating
// RULE2: double n saturating, subtract from m
// RULE3: every word step clamps to signed 32 bits
// RULE4: double ops set sticky flag, never clear
// RULE5: word subtract m minus n, saturated 32
// RULE6: word subtract sets flag only on saturation
// RULE7: exchange op low = nLow plus mHigh
// RULE8: exchange op high = nHigh minus mLow
// RULE9: two independent saturating halfword subtractions
// RULE10: upper lane bits 31:16, lower 15:0
// RULE11: four independent saturating signed byte subtractions
// RULE12: each byte lane from same operand lane
// RULE13: source never names register 13 or 15 (not checked: the decode accepts any register field)
// RULE14: parallel ops never touch sticky flag
// RULE15: act only when condition passed
// RULE16: decode opcode bits, register fields fixed
`timescale 1ns/1ps
`default_nettype none
`include "sat_sub_params.svh"
module sat_sub_dsp_ops (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        instrValid,
    input  wire logic        condPassed,
    input  wire logic [15:0] instrHi,
    input  wire logic [15:0] instrLo,
    input  wire logic [31:0] nOperand,
    input  wire logic [31:0] mOperand,
    input  wire logic        stickyClear,
    output logic      [31:0] resultData_r,
    output logic      [3:0]  resultIdx_r,
    output logic             resultWrite_r,
    output logic             stickySatFlag_r,
    output logic             illegalOp_r
);
    // ******************************************************
    // decode
    // ******************************************************
    logic [3:0]       hiSel;      // selector nibble of first halfword
    logic [3:0]       loSel;      // selector nibble of second halfword
    logic             fixedOk;    // constant opcode bits match
    sat_sub_pkg::op_t op;         // decoded operation
    logic             acceptOp;   // a known operation whose condition passed
    logic             isDouble;   // either double operation
    logic             isParallel; // lane operations

    assign hiSel   = instrHi[`SSD_HI_SEL_MSB:`SSD_HI_SEL_LSB];
    assign loSel   = instrLo[`SSD_LO_SEL_MSB:`SSD_LO_SEL_LSB];
    assign fixedOk = (instrHi[`SSD_HI_TOP_MSB:`SSD_HI_TOP_LSB] == `SSD_HI_TOP)
                   && (instrLo[`SSD_LO_TOP_MSB:`SSD_LO_TOP_LSB] == `SSD_LO_TOP);
    // both selector nibbles must match, so a near miss never aliases onto an operation
    assign op = !fixedOk ? sat_sub_pkg::OP_NONE :                                     // [RULE16]
        (hiSel == `SSD_HI_WORD && loSel == `SSD_LO_DADD) ? sat_sub_pkg::OP_DADD :
        (hiSel == `SSD_HI_WORD && loSel == `SSD_LO_DSUB) ? sat_sub_pkg::OP_DSUB :
        (hiSel == `SSD_HI_WORD && loSel == `SSD_LO_SUB)  ? sat_sub_pkg::OP_SUBW :
        (hiSel == `SSD_HI_SAX  && loSel == `SSD_LO_PAR)  ? sat_sub_pkg::OP_SAX  :
        (hiSel == `SSD_HI_HALF && loSel == `SSD_LO_PAR)  ? sat_sub_pkg::OP_HALF :
        (hiSel == `SSD_HI_BYTE && loSel == `SSD_LO_PAR)  ? sat_sub_pkg::OP_BYTE :
        sat_sub_pkg::OP_NONE;
    // a failed condition has no architectural effect at all
    assign acceptOp   = instrValid && condPassed && (op != sat_sub_pkg::OP_NONE); // [RULE15]
    assign isDouble   = (op == sat_sub_pkg::OP_DADD) || (op == sat_sub_pkg::OP_DSUB);
    assign isParallel = (op == sat_sub_pkg::OP_SAX) || (op == sat_sub_pkg::OP_HALF)
                      || (op == sat_sub_pkg::OP_BYTE);

    // ******************************************************
    // word path
    // ******************************************************
    logic [31:0] doubled;   // n doubled and clamped
    logic        dblSat;    // doubling saturated
    logic [31:0] wordB;     // second operand of the word step
    logic [31:0] wordRes;   // clamped word result
    logic        wordSat;   // word step saturated
    logic        wordSub;   // word step subtracts

    // doubling is n + n through the same clamp as every other word step
    sat_lane #(.WIDTH(32)) dblLane (                                                 // [RULE3]
        .opA       (nOperand),
        .opB       (nOperand),
        .subtract  (1'b0),
        .result    (doubled),
        .saturated (dblSat)
    );
    assign wordB   = (op == sat_sub_pkg::OP_SUBW) ? nOperand : doubled;               // [RULE5]
    assign wordSub = (op != sat_sub_pkg::OP_DADD);                                    // [RULE1] [RULE2]
    sat_lane #(.WIDTH(32)) wordLane (                                                // [RULE3]
        .opA       (mOperand),
        .opB       (wordB),
        .subtract  (wordSub),
        .result    (wordRes),
        .saturated (wordSat)
    );

    // ******************************************************
    // halfword path
    // ******************************************************
    logic        isSax;     // exchange variant
    logic [15:0] halfHiB;   // m lane feeding the upper lane
    logic [15:0] halfLoB;   // m lane feeding the lower lane
    logic [31:0] halfRes;   // packed halfword result

    assign isSax   = (op == sat_sub_pkg::OP_SAX);
    // exchange swaps the m halves; the lower lane adds, the upper subtracts
    assign halfHiB = isSax ? mOperand[15:0] : mOperand[31:16];                        // [RULE8] [RULE10]
    assign halfLoB = isSax ? mOperand[31:16] : mOperand[15:0];                        // [RULE7] [RULE10]
    sat_lane #(.WIDTH(16)) halfHiLane (                                              // [RULE9]
        .opA       (nOperand[31:16]),
        .opB       (halfHiB),
        .subtract  (1'b1),
        .result    (halfRes[31:16]),
        .saturated ()
    );
    sat_lane #(.WIDTH(16)) halfLoLane (                                              // [RULE9]
        .opA       (nOperand[15:0]),
        .opB       (halfLoB),
        .subtract  (!isSax),
        .result    (halfRes[15:0]),
        .saturated ()
    );

    // ******************************************************
    // byte path
    // ******************************************************
    logic [31:0] byteRes;   // packed byte result

    // lane saturation is deliberately not collected: parallel ops leave the flag alone
    for (genvar lane = 0; lane < 4; lane++) begin : gByte
        sat_lane #(.WIDTH(8)) byteLane (                                             // [RULE11] [RULE12]
            .opA       (nOperand[lane*8 +: 8]),
            .opB       (mOperand[lane*8 +: 8]),
            .subtract  (1'b1),
            .result    (byteRes[lane*8 +: 8]),
            .saturated ()
        );
    end

    // ******************************************************
    // result select and flag
    // ******************************************************
    logic [31:0] resultSel;  // result of the decoded operation
    logic        satEvent;   // operation that may set the sticky flag saturated
    logic        flag_nxt;   // next sticky flag

    assign resultSel = (op == sat_sub_pkg::OP_BYTE) ? byteRes :
                       isParallel ? halfRes : wordRes;
    // doubling saturation counts only for the double operations
    assign satEvent  = acceptOp && !isParallel                                        // [RULE14]
                     && (wordSat || (isDouble && dblSat));                            // [RULE4] [RULE6]
    // a set in the same cycle as a clear wins, so no saturation is lost
    assign flag_nxt  = satEvent || (stickySatFlag_r && !stickyClear);

    // write-back strobe, destination and data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resultWrite_r <= 1'b0;
            resultData_r  <= `SSD_RST_DATA;
            resultIdx_r   <= `SSD_RST_IDX;
        end else begin
            resultWrite_r <= acceptOp;                                                // [RULE15]
            if (acceptOp) begin
                resultData_r <= resultSel;
                resultIdx_r  <= instrLo[`SSD_D_MSB:`SSD_D_LSB];                       // [RULE16]
            end
        end
    end

    // sticky saturation flag and unknown-encoding pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stickySatFlag_r <= `SSD_RST_FLAG;
            illegalOp_r     <= 1'b0;
        end else begin
            stickySatFlag_r <= flag_nxt;                                              // [RULE4]
            illegalOp_r     <= instrValid && (op == sat_sub_pkg::OP_NONE);
        end
    end

    // ******************************************************
    // checks
    // ******************************************************
    // independent reference: exact wide arithmetic, then clamp
    function automatic logic [31:0] clamp32(input logic signed [33:0] v);
        if (v > 34'sh0_7FFF_FFFF) return 32'h7FFF_FFFF;
        if (v < -34'sh0_8000_0000) return 32'h8000_0000;
        return v[31:0];
    endfunction
    function automatic logic [15:0] clamp16(input logic signed [17:0] v);
        if (v > 18'sh0_7FFF) return 16'h7FFF;
        if (v < -18'sh0_8000) return 16'h8000;
        return v[15:0];
    endfunction
    function automatic logic [7:0] clamp8(input logic signed [9:0] v);
        if (v > 10'sh07F) return 8'h7F;
        if (v < -10'sh080) return 8'h80;
        return v[7:0];
    endfunction

    logic signed [33:0] sN;     // n widened
    logic signed [33:0] sM;     // m widened
    logic signed [33:0] sDbl;   // reference doubled n widened
    logic [31:0] refDbl;        // reference doubled n
    logic [31:0] refDadd;       // reference double-and-add
    logic [31:0] refDsub;       // reference double-and-subtract
    logic [31:0] refSub;        // reference word subtract
    logic        refSubSat;     // reference word subtract saturates
    logic [15:0] refSaxLo;      // reference exchange low lane
    logic [15:0] refSaxHi;      // reference exchange high lane
    logic [15:0] refHalfHi;     // reference upper halfword difference
    logic [7:0]  refByte3;      // reference top byte difference

    assign sN        = {{2{nOperand[31]}}, nOperand};
    assign sM        = {{2{mOperand[31]}}, mOperand};
    assign refDbl    = clamp32(sN + sN);
    assign sDbl      = {{2{refDbl[31]}}, refDbl};
    assign refDadd   = clamp32(sM + sDbl);
    assign refDsub   = clamp32(sM - sDbl);
    assign refSub    = clamp32(sM - sN);
    assign refSubSat = (refSub != 32'((sM - sN)));
    assign refSaxLo  = clamp16({{2{nOperand[15]}}, nOperand[15:0]} + {{2{mOperand[31]}}, mOperand[31:16]});
    assign refSaxHi  = clamp16({{2{nOperand[31]}}, nOperand[31:16]} - {{2{mOperand[15]}}, mOperand[15:0]});
    assign refHalfHi = clamp16({{2{nOperand[31]}}, nOperand[31:16]} - {{2{mOperand[31]}}, mOperand[31:16]});
    assign refByte3  = clamp8({{2{nOperand[31]}}, nOperand[31:24]} - {{2{mOperand[31]}}, mOperand[31:24]});

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_DADD_RESULT: assert property (acceptOp && op == sat_sub_pkg::OP_DADD |=> // [RULE1]
        resultData_r == $past(refDadd)) else $error("double-add result wrong");
    AST_DSUB_RESULT: assert property (acceptOp && op == sat_sub_pkg::OP_DSUB |=> // [RULE2]
        resultData_r == $past(refDsub)) else $error("double-subtract result wrong");
    AST_DOUBLE_CLAMP_FLAG: assert property (acceptOp && isDouble && refDbl != 32'(sN + sN) // [RULE3]
        |=> stickySatFlag_r) else $error("doubling clamp did not raise flag");
    AST_FLAG_HOLDS: assert property (stickySatFlag_r && !stickyClear |=> stickySatFlag_r // [RULE4]
        ) else $error("sticky flag dropped without clear");
    AST_SUB_RESULT: assert property (acceptOp && op == sat_sub_pkg::OP_SUBW |=> // [RULE5]
        resultData_r == $past(refSub) && resultWrite_r) else $error("word subtract result wrong");
    AST_SUB_FLAG: assert property (acceptOp && op == sat_sub_pkg::OP_SUBW && !stickySatFlag_r // [RULE6]
        |=> stickySatFlag_r == $past(refSubSat)) else $error("word subtract flag wrong");
    AST_SAX_LO: assert property (acceptOp && isSax |=> // [RULE7]
        resultData_r[15:0] == $past(refSaxLo)) else $error("exchange low lane wrong");
    AST_SAX_HI: assert property (acceptOp && isSax |=> // [RULE8]
        resultData_r[31:16] == $past(refSaxHi)) else $error("exchange high lane wrong");
    AST_HALF_HI: assert property (acceptOp && op == sat_sub_pkg::OP_HALF |=> // [RULE9] [RULE10]
        resultData_r[31:16] == $past(refHalfHi)) else $error("upper halfword lane wrong");
    AST_BYTE_TOP: assert property (acceptOp && op == sat_sub_pkg::OP_BYTE |=> // [RULE11] [RULE12]
        resultData_r[31:24] == $past(refByte3)) else $error("top byte lane wrong");
    AST_PAR_NO_FLAG: assert property (acceptOp && isParallel && !stickySatFlag_r // [RULE14]
        |=> !stickySatFlag_r) else $error("parallel op changed flag");
    AST_COND_GATES: assert property (instrValid && !condPassed && !stickySatFlag_r // [RULE15]
        |=> !resultWrite_r && !stickySatFlag_r) else $error("failed condition had an effect");
    AST_DEST_FIELD: assert property (acceptOp |=> resultWrite_r // [RULE16]
        && resultIdx_r == $past(instrLo[`SSD_D_MSB:`SSD_D_LSB])) else $error("destination field wrong");
endmodule
`default_nettype wire

/* test/core_model.sv */
// core-side model: register file that feeds both operands and takes the write-back
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic        clk,
    input  wire logic [15:0] instrHi,
    input  wire logic [15:0] instrLo,
    input  wire logic        resultWrite_r,
    input  wire logic [3:0]  resultIdx_r,
    input  wire logic [31:0] resultData_r,
    output logic      [31:0] nOperand,
    output logic      [31:0] mOperand
);
    // ****************************************
    // register file
    // ****************************************
    logic [31:0] regFile [16]; // preset by the bench before each instruction

    // operand reads follow the register fields of the presented instruction
    assign nOperand = regFile[instrHi[3:0]];
    assign mOperand = regFile[instrLo[3:0]];

    // write-back lands after the datapath has sampled its operands
    always @(posedge clk) begin
        if (resultWrite_r) begin
            regFile[resultIdx_r] <= resultData_r;
        end
    end
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the saturating subtract datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ****************************************
    // signals and bench state
    // ****************************************
    logic        clk;
    logic        reset_n;
    logic        instrValid;
    logic        condPassed;
    logic [15:0] instrHi;
    logic [15:0] instrLo;
    logic        stickyClear;
    wire  [31:0] nOperand;
    wire  [31:0] mOperand;
    wire  [31:0] resultData_r;
    wire  [3:0]  resultIdx_r;
    wire         resultWrite_r;
    wire         stickySatFlag_r;
    wire         illegalOp_r;
    int          n_errors;
    int          cmp_count;
    int          cycles;
    logic [31:0] rnd;      // lfsr state
    logic        expFlag;  // modelled sticky flag
    logic [31:0] lastData; // last written result
    logic [3:0]  lastIdx;  // last written destination
    // selector nibbles per operation; entry 6 lies outside the family
    logic [3:0]  hiSel [7] = '{4'h8, 4'h8, 4'h8, 4'hE, 4'hD, 4'hC, 4'h9};
    logic [3:0]  loSel [7] = '{4'h9, 4'hB, 4'hA, 4'h1, 4'h1, 4'h1, 4'h8};
    logic [31:0] corner [7] = '{32'h7FFF_FFFF, 32'h8000_0000, 32'h4000_0000, 32'h0000_0001,
                                32'hFFFF_FFFF, 32'h8080_8080, 32'h7F7F_7F7F};

    sat_sub_dsp_ops dut (.clk(clk), .reset_n(reset_n), .instrValid(instrValid), .condPassed(condPassed),
        .instrHi(instrHi), .instrLo(instrLo), .nOperand(nOperand), .mOperand(mOperand),
        .stickyClear(stickyClear), .resultData_r(resultData_r), .resultIdx_r(resultIdx_r),
        .resultWrite_r(resultWrite_r), .stickySatFlag_r(stickySatFlag_r), .illegalOp_r(illegalOp_r));
    core_model core (.clk(clk), .instrHi(instrHi), .instrLo(instrLo), .resultWrite_r(resultWrite_r),
        .resultIdx_r(resultIdx_r), .resultData_r(resultData_r), .nOperand(nOperand), .mOperand(mOperand));

    // ****************************************
    // reference arithmetic
    // ****************************************
    function automatic logic [31:0] nextRand(logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
    endfunction
    // sign-extend the low w bits
    function automatic longint sx(logic [31:0] v, int w);
        longint t;
        t = longint'(v) & ((64'sd1 <<< w) - 1);
        return (t >= (64'sd1 <<< (w - 1))) ? t - (64'sd1 <<< w) : t;
    endfunction
    // clamp to signed w bits, flagging any clamp
    function automatic longint clampv(longint v, int w, inout logic s);
        longint lim;
        lim = 64'sd1 <<< (w - 1);
        if (v > lim - 1) begin
            s = 1'b1;
            return lim - 1;
        end
        if (v < -lim) begin
            s = 1'b1;
            return -lim;
        end
        return v;
    endfunction
    function automatic logic [31:0] calc(int op, logic [31:0] n, logic [31:0] m, inout logic s);
        logic [31:0] r;
        longint      dbl;
        logic        q;  // lane saturation is discarded
        int          w;
        r = 32'h0000_0000;
        q = 1'b0;
        w = (op == 4) ? 16 : 8;
        case (op)
            0, 1: begin
                dbl = clampv(2 * sx(n, 32), 32, s);
                r = 32'(clampv(sx(m, 32) + (op == 0 ? dbl : -dbl), 32, s));
            end
            2: r = 32'(clampv(sx(m, 32) - sx(n, 32), 32, s));
            3: r = {16'(clampv(sx(n >> 16, 16) - sx(m, 16), 16, q)),
                    16'(clampv(sx(n, 16) + sx(m >> 16, 16), 16, q))};
            4, 5: for (int k = 0; k < 32 / w; k++) begin
                r = r | ((32'(clampv(sx(n >> (k * w), w) - sx(m >> (k * w), w), w, q))
                          & ((32'h1 << w) - 1)) << (k * w));
            end
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // present one instruction, back to back with the previous one, and check it a cycle later
    task automatic runOp(int op, logic [31:0] nv, logic [31:0] mv, logic cond, logic clr);
        logic [3:0]  d;
        logic [3:0]  nIdx;
        logic [3:0]  mIdx;
        logic        s;
        logic [31:0] e;
        rnd = nextRand(rnd);
        d = 4'(rnd[7:0] % 13);
        nIdx = 4'(rnd[11:8] % 6);
        mIdx = 4'(6 + rnd[15:12] % 6);
        core.regFile[nIdx] = nv;
        core.regFile[mIdx] = mv;
        instrValid = 1'b1;
        condPassed = cond;
        stickyClear = clr;
        instrHi = {8'hFA, hiSel[op], nIdx};
        instrLo = {4'hF, d, loSel[op], mIdx};
        s = 1'b0;
        e = calc(op, nv, mv, s);
        if (clr) expFlag = 1'b0;
        if (cond && op < 3 && s) expFlag = 1'b1; // set wins over clear
        if (cond && op < 6) begin
            lastData = e;
            lastIdx = d;
        end
        @(posedge clk);
        #1;
        check("write", 32'(resultWrite_r), 32'(cond && op < 6));
        check("data", resultData_r, lastData);
        check("index", 32'(resultIdx_r), 32'(lastIdx));
        check("flag", 32'(stickySatFlag_r), 32'(expFlag));
        check("illegal", 32'(illegalOp_r), 32'(op == 6));
    endtask
    // a cycle with no instruction, optionally clearing the flag
    task automatic idle(logic clr);
        instrValid = 1'b0;
        stickyClear = clr;
        @(posedge clk);
        #1;
        if (clr) expFlag = 1'b0;
        check("flag", 32'(stickySatFlag_r), 32'(expFlag));
        check("write", 32'(resultWrite_r), 32'h0);
    endtask

    // ****************************************
    // clock, timeout and test sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        {reset_n, instrValid, condPassed, stickyClear, expFlag} = 5'h00;
        {instrHi, instrLo, lastData, lastIdx} = 68'h0;
        n_errors = 0;
        cmp_count = 0;
        cycles = 0;
        rnd = 32'h80EF;
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        check("reset data", resultData_r, 32'h0000_0000);
        check("reset flag", 32'(stickySatFlag_r), 32'h0);
        for (int op = 0; op < 7; op++) begin
            for (int i = 0; i < 7; i++) runOp(op, corner[i], corner[(i + 3) % 7], 1'b1, 1'b0);
        end
        idle(1'b1);
        $display("test corners done");
        for (int op = 0; op < 7; op++) runOp(op, 32'h7FFF_FFFF, 32'h8000_0000, 1'b0, 1'b0);
        $display("test condition fail done");
        runOp(2, 32'h8000_0000, 32'h0000_0000, 1'b1, 1'b0);
        idle(1'b1);
        runOp(2, 32'h8000_0000, 32'h0000_0000, 1'b1, 1'b1);
        idle(1'b1);
        runOp(5, 32'h8080_8080, 32'h7F7F_7F7F, 1'b1, 1'b0);
        // both exchange lanes clamp here, so a leaked lane saturation would show on the flag
        runOp(3, 32'h7FFF_8000, 32'h8000_8000, 1'b1, 1'b0);
        $display("test sticky flag done");
        repeat (300) begin
            logic [31:0] a;
            rnd = nextRand(rnd);
            a = rnd;
            rnd = nextRand(rnd);
            runOp(int'(rnd[26:24]) % 7, a, rnd, rnd[0] | rnd[1], rnd[5:3] == 3'h0);
        end
        idle(1'b0);
        $display("test random done");
        results();
    end
endmodule
`default_nettype wire
